// *** rtl/usb_event_consts.svh ***
// Purpose: Offsets, field positions and reset values of the event status block
// Assumes: Byte offsets of the internal register space mapped onto word slots
// Notes:   Definitions only
`ifndef USB_EVENT_CONSTS_SVH
`define USB_EVENT_CONSTS_SVH

// Register indices as printed; byte address is four times the index
`define STATUS_INDEX      12'h00A
`define ENABLE_INDEX      12'h00B
`define CONTROL_INDEX     12'h00C
`define STATUS_ADDR       12'h028
`define ENABLE_ADDR       12'h02C
`define CONTROL_ADDR      12'h030

`define STATUS_RESET      8'h00
`define ENABLE_RESET      8'h06
`define CONTROL_RESET     8'h00

// Field positions
`define BIT_DETACH        5
`define BIT_ATTACH        4
`define BIT_SOF           3
`define BIT_BABBLE        2
`define BIT_BUSRESET      2
`define BIT_RESUME        1
`define BIT_SUSPEND       0

// Control register: bit 0 selects host role
`define CTRL_HOST_BIT     0

`define HOST_VALID_MASK   8'h3E
`define DEV_VALID_MASK    8'h0F

`endif

// *** rtl/usb_event_pkg.sv ***
// Purpose: Types shared by the event status block
// Assumes: Nothing beyond the constants header
// Notes:   Bus event bundle travels as one packed struct
package usb_event_pkg;

    typedef struct packed {
        logic detach;
        logic attach;
        logic sof;
        logic babble;
        logic bus_reset;
        logic resume;
        logic suspend;
    } bus_event_type;

    typedef enum logic [1:0] {
        HTRANS_IDLE   = 2'b00,
        HTRANS_BUSY   = 2'b01,
        HTRANS_NONSEQ = 2'b10,
        HTRANS_SEQ    = 2'b11
    } htrans_type;

endpackage : usb_event_pkg

// *** rtl/event_sync.sv ***
// Purpose: Two-stage synchroniser and rising-edge detector per event line
// Assumes: Event lines come from pins outside the clock domain
// Notes:   First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module event_sync #(
    parameter int WIDTH = 7
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] pulse_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] last_q;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_line
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                    last_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= async_i[g];
                    sync_q[g] <= meta_q[g];
                    last_q[g] <= sync_q[g];
                end
            end
            assign pulse_o[g] = sync_q[g] & ~last_q[g];
        end
    endgenerate
endmodule : event_sync
`default_nettype wire

// *** rtl/usb_general_event_status.sv ***
// Purpose: General bus event status latch with read-to-clear and enable gating
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   Event pins are asynchronous levels; each rising edge is one event
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "usb_event_consts.svh"
module usb_general_event_status (
    input  wire logic                         CLK_I,
    input  wire logic                         RSTN_I,
    input  wire logic                         HSEL_I,
    input  wire logic [11:0]                  HADDR_I,
    input  wire usb_event_pkg::htrans_type    HTRANS_I,
    input  wire logic                         HWRITE_I,
    input  wire logic [2:0]                   HSIZE_I,
    input  wire logic [31:0]                  HWDATA_I,
    input  wire logic                         HREADY_I,
    input  wire usb_event_pkg::bus_event_type BUS_EVENT_I,
    input  wire logic                         SUSPENDED_I,
    output logic [31:0]                       HRDATA_O,
    output logic                              HREADYOUT_O,
    output logic                              HRESP_O,
    output logic                              HOST_ROLE_O,
    output logic                              IRQ_O
);
    import usb_event_pkg::*;

    // ------------------------------------------------------------
    // Event capture
    // ------------------------------------------------------------
    bus_event_type ev;
    logic [6:0]    ev_raw;
    logic [6:0]    ev_pulse;
    logic          susp_meta_q;
    logic          susp_q;

    assign ev_raw = BUS_EVENT_I;

    event_sync #(
        .WIDTH (7)
    ) u_sync (
        .clk_i   (CLK_I),
        .rstn_i  (RSTN_I),
        .async_i (ev_raw),
        .pulse_o (ev_pulse)
    );

    assign ev = ev_pulse;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            susp_meta_q <= 1'b0;
            susp_q      <= 1'b0;
        end else begin
            susp_meta_q <= SUSPENDED_I;
            susp_q      <= susp_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic        ap_valid;
    logic        wr_pend_q;
    logic        rd_stat_q;
    logic [11:0] addr_q;
    logic        rd_status;
    logic        wr_enable;
    logic        wr_control;

    assign ap_valid   = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ ||
                        HTRANS_I == HTRANS_SEQ);
    // Status read is cleared in the data phase, after hrdata is set up
    assign rd_status  = rd_stat_q;
    assign wr_enable  = wr_pend_q && addr_q == `ENABLE_ADDR;
    assign wr_control = wr_pend_q && addr_q == `CONTROL_ADDR;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_pend_q <= 1'b0;
            rd_stat_q <= 1'b0;
            addr_q    <= 12'h000;
        end else begin
            wr_pend_q <= ap_valid && HWRITE_I;
            rd_stat_q <= ap_valid && !HWRITE_I && HADDR_I == `STATUS_ADDR;
            addr_q    <= HADDR_I;
        end
    end

    // ------------------------------------------------------------
    // Role and enable registers
    // ------------------------------------------------------------
    logic [7:0] enable_q;
    logic       host_q;
    logic       sof_seen_q;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            enable_q <= `ENABLE_RESET;
            host_q   <= 1'b0;
        end else begin
            if (wr_enable) begin
                enable_q <= HWDATA_I[7:0];
            end
            if (wr_control) begin
                host_q <= HWDATA_I[`CTRL_HOST_BIT];
            end
        end
    end

    // Babble is ignored until the host has sent one frame start
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sof_seen_q <= 1'b0;
        end else if (!host_q) begin
            sof_seen_q <= 1'b0;
        end else if (ev.sof) begin
            sof_seen_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    logic [7:0] set_vec;
    logic [7:0] valid_mask;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] clear_vec;

    assign valid_mask = host_q ? `HOST_VALID_MASK : `DEV_VALID_MASK;

    assign set_vec[7:6]          = 2'b00;
    assign set_vec[`BIT_DETACH]  = host_q & ev.detach;
    assign set_vec[`BIT_ATTACH]  = host_q & ev.attach;
    assign set_vec[`BIT_SOF]     = ev.sof;
    assign set_vec[`BIT_BABBLE]  = host_q ? (ev.babble & sof_seen_q)
                                          : ev.bus_reset;
    assign set_vec[`BIT_RESUME]  = ev.resume & susp_q;
    assign set_vec[`BIT_SUSPEND] = ~host_q & ev.suspend;

    // Only flags the read returned are cleared; a flag that lands after
    // the data was taken waits for the next read
    assign clear_vec = rd_status ? HRDATA_O[7:0] : 8'h00;
    // New events win over the read clear; writes never reach status
    assign status_d = ((status_q & ~clear_vec) | set_vec)
                      & valid_mask;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            status_q <= `STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // ------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    logic       irq_d;

    assign rd_byte = (HADDR_I == `STATUS_ADDR)  ? status_q :
                     (HADDR_I == `ENABLE_ADDR)  ? (enable_q & valid_mask) :
                     (HADDR_I == `CONTROL_ADDR) ? {7'h00, host_q} : 8'h00;
    assign irq_d   = |(status_d & enable_q);

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            HRDATA_O    <= 32'h0000_0000;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            HOST_ROLE_O <= 1'b0;
            IRQ_O       <= 1'b0;
        end else begin
            HRDATA_O    <= (ap_valid && !HWRITE_I) ? {24'h000000, rd_byte}
                                                   : 32'h0000_0000;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            HOST_ROLE_O <= host_q;
            IRQ_O       <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    read_clears_a: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I)
        rd_status && set_vec == 8'h00 && $past(set_vec) == 8'h00
        |=> status_q == 8'h00)
        else $error("status not cleared by read");
    event_kept_a: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I)
        rd_status && set_vec[`BIT_SOF] |=> status_q[`BIT_SOF])
        else $error("event lost during read");
    sof_sets_a: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I)
        ev.sof |=> status_q[`BIT_SOF])
        else $error("frame start not flagged");
    write_ignored_a: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I)
        wr_pend_q && addr_q == `STATUS_ADDR && set_vec == 8'h00
        && $stable(host_q) |=> status_q == $past(status_q))
        else $error("write changed status");
    host_bit0_a: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I)
        host_q && $past(host_q) |-> !status_q[`BIT_SUSPEND])
        else $error("suspend flag set in host role");
    babble_gate_a: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I)
        host_q && !sof_seen_q && ev.babble && !rd_status
        && !status_q[`BIT_BABBLE] |=> !status_q[`BIT_BABBLE])
        else $error("babble flagged before first frame");
    detach_sets_a: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I)
        host_q && ev.detach |=> status_q[`BIT_DETACH])
        else $error("detach not flagged");
    attach_sets_a: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I)
        host_q && ev.attach |=> status_q[`BIT_ATTACH])
        else $error("attach not flagged");
    resume_gate_a: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I)
        ev.resume && susp_q |=> status_q[`BIT_RESUME])
        else $error("resume not flagged");
    irq_gate_a: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I)
        IRQ_O |-> |($past(status_d) & $past(enable_q)))
        else $error("request without enabled flag");
    // Host bits linger for one cycle after a role change, then are masked
    upper_zero_a: assert property (@(posedge CLK_I)
        disable iff (!RSTN_I)
        status_q[7:6] == 2'b00
        && (host_q || $past(host_q) || status_q[5:4] == 2'b00))
        else $error("reserved status bits set");
endmodule : usb_general_event_status
`default_nettype wire

// *** test/usb_peer_model.sv ***
// Purpose: Bus peer that raises event lines and the suspended level
// Assumes: Event lines idle low between events
// Notes:   Each event is one rising edge held long enough to sync
`timescale 1ns/100ps
`default_nettype none
module usb_peer_model (
    input  wire logic                          clk_i,
    output var  usb_event_pkg::bus_event_type  bus_event_o,
    output var  logic                          suspended_o
);
    import usb_event_pkg::*;
    // ---------------------------------------------------------------
    // Event lines
    // ---------------------------------------------------------------
    initial begin
        bus_event_o = '0;
        suspended_o = 1'b0;
    end
    // Resume is only signalled while the system clock runs
    task fire(input int idx);
        @(posedge clk_i);
        bus_event_o[idx] <= 1'b1;
        repeat (3) @(posedge clk_i);
        bus_event_o[idx] <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : fire
    task set_susp(input logic v);
        @(posedge clk_i);
        suspended_o <= v;
        repeat (4) @(posedge clk_i);
    endtask : set_susp
endmodule : usb_peer_model
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the general event status latch
// Assumes: AHB-Lite single word transfers, one slave
// Notes:   Event bit order in the bundle: detach 6 down to suspend 0
`timescale 1ns/100ps
`default_nettype none
`include "usb_event_consts.svh"
module tb_top;
    import usb_event_pkg::*;
    // ---------------------------------------------------------------
    // Signals and instances
    // ---------------------------------------------------------------
    logic          clk = 1'b0;
    logic          rstn = 1'b0;
    logic          hsel = 1'b0;
    logic [11:0]   haddr = 12'h000;
    htrans_type    htrans = HTRANS_IDLE;
    logic          hwrite = 1'b0;
    logic [2:0]    hsize = 3'h2;
    logic [31:0]   hwdata = 32'h0;
    logic [31:0]   hrdata;
    logic          hready;
    logic          hresp;
    logic          host;
    logic          irq;
    bus_event_type bev;
    logic          susp;
    int            fails = 0;
    int            total_checks = 0;
    always #20 clk = ~clk;
    usb_peer_model u_peer (.clk_i(clk), .bus_event_o(bev), .suspended_o(susp));
    usb_general_event_status u_dut (
        .CLK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
        .HWDATA_I(hwdata), .HREADY_I(hready), .BUS_EVENT_I(bev),
        .SUSPENDED_I(susp), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(hresp), .HOST_ROLE_O(host), .IRQ_O(irq));
    // ---------------------------------------------------------------
    // Bus and compare tasks
    // ---------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= HTRANS_IDLE;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
        repeat (2) @(posedge clk);
    endtask : wr
    task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        chk(nm, e, x);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : rdchk
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task t_reset;
        rdchk("status", `STATUS_ADDR, 32'h00000000);
        rdchk("enable", `ENABLE_ADDR, 32'h00000006);
        rdchk("unmapped", 12'h040, 32'h00000000);
    endtask : t_reset
    task t_readonly;
        u_peer.fire(4);
        wr(`STATUS_ADDR, 32'h000000FF);
        rdchk("status_ro", `STATUS_ADDR, 32'h00000008);
        rdchk("status_clr", `STATUS_ADDR, 32'h00000000);
    endtask : t_readonly
    task t_device;
        u_peer.fire(6);
        u_peer.fire(5);
        u_peer.fire(2);
        u_peer.fire(0);
        u_peer.fire(1);
        rdchk("dev_ev", `STATUS_ADDR, 32'h00000005);
        u_peer.set_susp(1'b1);
        u_peer.fire(1);
        rdchk("dev_resume", `STATUS_ADDR, 32'h00000002);
        u_peer.set_susp(1'b0);
    endtask : t_device
    task t_irq;
        wr(`ENABLE_ADDR, 32'h00000000);
        u_peer.fire(4);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(`ENABLE_ADDR, 32'h00000008);
        chk("irq_on", 32'h1, {31'h0, irq});
        rdchk("irq_stat", `STATUS_ADDR, 32'h00000008);
        repeat (2) @(posedge clk);
        chk("irq_off", 32'h0, {31'h0, irq});
    endtask : t_irq
    task t_host;
        wr(`CONTROL_ADDR, 32'h00000001);
        chk("host_role", 32'h1, {31'h0, host});
        u_peer.fire(3);
        u_peer.fire(5);
        u_peer.fire(6);
        u_peer.fire(0);
        rdchk("host_ev", `STATUS_ADDR, 32'h00000030);
        u_peer.fire(4);
        u_peer.fire(3);
        rdchk("host_babble", `STATUS_ADDR, 32'h0000000C);
        wr(`CONTROL_ADDR, 32'h00000000);
    endtask : t_host
    // Frame start lands in the read's data phase, then one cycle earlier
    task t_readclr;
        fork
            u_peer.fire(4);
            begin
                @(posedge clk);
                rdchk("race_read", `STATUS_ADDR, 32'h00000000);
            end
        join
        rdchk("race_kept", `STATUS_ADDR, 32'h00000008);
        fork
            u_peer.fire(4);
            begin
                repeat (2) @(posedge clk);
                rdchk("late_read", `STATUS_ADDR, 32'h00000000);
            end
        join
        rdchk("late_kept", `STATUS_ADDR, 32'h00000008);
    endtask : t_readclr
    // Reset in mid-run with a flag pending and host role selected
    task t_rerun;
        wr(`CONTROL_ADDR, 32'h00000001);
        u_peer.fire(4);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdchk("status_rst", `STATUS_ADDR, 32'h00000000);
        rdchk("enable_rst", `ENABLE_ADDR, 32'h00000006);
        chk("host_rst", 32'h0, {31'h0, host});
    endtask : t_rerun
    // ---------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ---------------------------------------------------------------
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_readonly;
        t_device;
        t_irq;
        t_host;
        t_readclr;
        t_rerun;
        summarize;
    end
    // Whole run needs well under 1000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize;
    end
endmodule : tb_top
`default_nettype wire
